// *** core/gfx_pkg.sv ***
// Shared constants and carriers of the drawing pipeline.
package gfx_pkg;
	localparam int CQ_DEPTH      = 64;
	localparam int WB_DEPTH      = 16;
	localparam int PEQ_DEPTH     = 4;
	localparam int CBUF_DEPTH    = 8;
	localparam int LINE_MAX      = 16;
	localparam int SPAN_MAX      = 32;
	localparam logic [11:0] LINE_PITCH = 12'h400;
	localparam logic [5:0] REG_STATUS = 6'h00;
	localparam logic [5:0] REG_ROP    = 6'h01;
	localparam logic [5:0] REG_MODE   = 6'h02;
	localparam logic [5:0] REG_SCOPY  = 6'h03;
	localparam logic [5:0] REG_FG     = 6'h04;
	localparam logic [5:0] REG_BG     = 6'h05;
	localparam logic [5:0] REG_SPANW  = 6'h07;
	localparam logic [2:0] REG_SLOPE_GRP = 3'h1;
	localparam logic [2:0] REG_NOGO_GRP  = 3'h2;
	localparam logic [5:0] REG_CONT   = 6'h18;
	localparam logic [2:0] MODE_SIMPLE  = 3'h0;
	localparam logic [2:0] MODE_STIPPLE = 3'h1;
	localparam logic [2:0] MODE_LINE    = 3'h2;
	localparam logic [2:0] MODE_COPY    = 3'h3;
	localparam logic [2:0] MODE_FILL    = 3'h4;
	localparam logic [6:0] MODE_RESET   = 7'h00;
	localparam logic [3:0] ROP_RESET    = 4'hc;

	typedef enum logic [2:0] {
		PE_PIXEL = 3'h0,
		PE_SPAN  = 3'h1,
		PE_LINE  = 3'h2,
		PE_CP_RD = 3'h3,
		PE_CP_WR = 3'h4
	} pe_kind_e;

	typedef struct packed {
		logic        is_addr;
		logic [31:0] word;
	} cq_entry_s;

	typedef struct packed {
		pe_kind_e    kind;
		logic [23:0] addr;
		logic [31:0] pattern;
		logic [5:0]  len;
		logic [1:0]  depth;
		logic        opaque;
		logic        dither;
		logic [31:0] fg;
		logic [31:0] bg;
		logic [3:0]  rop;
		logic [9:0]  err;
		logic [9:0]  inc1;
		logic [9:0]  inc2;
		logic [11:0] step1;
		logic [11:0] step2;
	} pe_cmd_s;

	typedef struct packed {
		logic        is_read;
		logic        rmw;
		logic [20:0] qaddr;
		logic [63:0] data;
		logic [7:0]  be;
		logic [3:0]  rop;
	} fb_wr_s;
endpackage

// *** core/graphics_command_pipeline.sv ***
// Command queue, parser, pixel engine, merge stage and write buffer.
`timescale 1ns/100ps

module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	// Full and empty come from the count, so back-pressure is exact.
	assign in_ready  = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data  = mem_q[rd_ptr_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage is written only on an accepted push.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module graphics_command_pipeline
	import gfx_pkg::*;
#(
	parameter logic [11:0] PITCH = gfx_pkg::LINE_PITCH
) (
	input  wire logic               core_clk,
	input  wire logic               reset_n,
	input  wire logic               cq_wr_valid,
	input  wire logic               cq_wr_is_read,
	input  wire gfx_pkg::cq_entry_s cq_wr_entry,
	output logic                    cq_wr_ready,
	input  wire logic               copy_rd_valid,
	input  wire logic [63:0]        copy_rd_data,
	output logic                    mem_wr_valid,
	output gfx_pkg::fb_wr_s         mem_wr,
	input  wire logic               mem_wr_ready,
	output logic                    pipe_idle
);
	import gfx_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DRAIN = 3'b010,
		ST_SPAN  = 3'b100
	} pstate_e;

	logic [1:0]  rst_sync_q;
	logic        rst_n;
	cq_entry_s   cq_out;
	logic        cq_valid, cq_pop;
	pe_cmd_s     pe_in, pe_out;
	logic        pe_in_valid, pe_in_ready, pe_out_valid, pe_pop;
	pstate_e     state_q;
	logic [23:0] cur_addr_q, lstart_q, fill_addr_q;
	logic        cur_reg_q, copy_phase_q;
	logic [3:0]  rop_q;
	logic [6:0]  mode_q;
	logic [31:0] fg_q, bg_q, scopy_q, fill_pat_q;
	logic [11:0] spanw_q, fill_rem_q, bpp_c, xstep_c, ystep_c;
	logic [5:0]  lt_len_q, len_c, idx;
	logic [9:0]  lt_err_q, lt_inc1_q, lt_inc2_q, err_c, inc1_c, inc2_c;
	logic [11:0] lt_step1_q, lt_step2_q, step1_c, step2_c;
	logic [8:0]  major_c, minor_c;
	logic [2:0]  oct_c;
	logic        is_data, reg_wr, fb_wr, slope_wr, width_wr, terms_wr, drained;

	// Reset enters asynchronously and is released through two flops.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	stream_fifo #(.WIDTH($bits(cq_entry_s)), .DEPTH(CQ_DEPTH)) u_cmd_queue (
		.clk       (core_clk),
		.rst_n     (rst_n),
		.in_valid  (cq_wr_valid & ~cq_wr_is_read),
		.in_data   (cq_wr_entry),
		.in_ready  (cq_wr_ready),
		.out_valid (cq_valid),
		.out_data  (cq_out),
		.out_ready (cq_pop)
	);
	// reads dropped: a read strobe is acknowledged but never stored above.

	// Decode of the entry at the head; registers are flagged by address bit 31.
	assign cq_pop   = (state_q == ST_IDLE) & cq_valid & pe_in_ready;
	assign is_data  = cq_pop & ~cq_out.is_addr;
	assign reg_wr   = is_data & cur_reg_q;
	assign fb_wr    = is_data & ~cur_reg_q;
	assign idx      = cur_addr_q[7:2];
	assign slope_wr = reg_wr & (idx[5:3] == REG_SLOPE_GRP);
	assign width_wr = reg_wr & (idx == REG_SPANW);
	assign terms_wr = slope_wr | width_wr | (reg_wr & (idx[5:3] == REG_NOGO_GRP));

	// line setup terms from rise and run, octant from the index.
	always_comb begin
		bpp_c   = 12'h1 << mode_q[5:4];
		oct_c   = width_wr ? 3'h0 : idx[2:0];
		major_c = oct_c[0] ? cq_out.word[24:16] : cq_out.word[8:0];
		minor_c = width_wr ? 9'h0 : (oct_c[0] ? cq_out.word[8:0] : cq_out.word[24:16]);
		len_c   = (major_c > 9'(LINE_MAX)) ? 6'(LINE_MAX) : major_c[5:0];
		err_c   = {minor_c, 1'b0} - {1'b0, major_c};
		inc1_c  = {minor_c, 1'b0};
		inc2_c  = {minor_c, 1'b0} - {major_c, 1'b0};
		xstep_c = oct_c[1] ? 12'h0 - bpp_c : bpp_c;
		ystep_c = oct_c[2] ? 12'h0 - PITCH : PITCH;
		step1_c = xstep_c + ystep_c;
		step2_c = oct_c[0] ? ystep_c : xstep_c;
	end

	// each command takes a snapshot of the live parameters.
	always_comb begin
		pe_in         = '0;
		pe_in.addr    = cur_addr_q;
		pe_in.pattern = cq_out.word;
		pe_in.depth   = mode_q[5:4];
		pe_in.opaque  = mode_q[3];
		pe_in.dither  = mode_q[6];
		pe_in.fg      = fg_q;
		pe_in.bg      = bg_q;
		pe_in.rop     = rop_q;
		pe_in.len     = lt_len_q;
		pe_in.err     = lt_err_q;
		pe_in.inc1    = lt_inc1_q;
		pe_in.inc2    = lt_inc2_q;
		pe_in.step1   = lt_step1_q;
		pe_in.step2   = lt_step2_q;
		pe_in.kind    = PE_PIXEL;
		pe_in_valid   = 1'b0;
		if (state_q == ST_SPAN) begin
			pe_in.kind    = PE_SPAN;
			pe_in.addr    = fill_addr_q;
			pe_in.pattern = fill_pat_q;
			pe_in.len     = (fill_rem_q > 12'(SPAN_MAX)) ? 6'(SPAN_MAX) : fill_rem_q[5:0];
			pe_in_valid   = 1'b1;
		end else if (slope_wr | width_wr | (reg_wr & idx == REG_CONT)) begin
			pe_in.kind    = PE_LINE;
			pe_in.addr    = lstart_q;
			pe_in.pattern = 32'hffffffff;
			if (slope_wr | width_wr) begin
				pe_in.len   = len_c;
				pe_in.err   = err_c;
				pe_in.inc1  = inc1_c;
				pe_in.inc2  = inc2_c;
				pe_in.step1 = step1_c;
				pe_in.step2 = step2_c;
			end
			pe_in_valid = 1'b1;
		end else if (fb_wr) begin
			pe_in_valid = (mode_q[2:0] != MODE_FILL);
			unique case (mode_q[2:0])
				MODE_STIPPLE: begin
					pe_in.kind = PE_SPAN;
					pe_in.len  = 6'(SPAN_MAX);
				end
				MODE_LINE: pe_in.kind = PE_LINE;
				MODE_COPY: pe_in.kind = copy_phase_q ? PE_CP_WR : PE_CP_RD;
				default:   pe_in.kind = PE_PIXEL;
			endcase
		end
	end

	// burst data takes the next word address after each entry.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_addr_q <= 24'h0;
			cur_reg_q  <= 1'b0;
		end else if (cq_pop) begin
			if (cq_out.is_addr) begin
				cur_addr_q <= cq_out.word[23:0];
				cur_reg_q  <= cq_out.word[31];
			end else begin
				cur_addr_q <= cur_addr_q + 24'h4;
			end
		end
	end

	// Parameter registers; the deep register is not kept here at all.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rop_q   <= ROP_RESET;
			mode_q  <= MODE_RESET;
			fg_q    <= 32'h0;
			bg_q    <= 32'h0;
			scopy_q <= 32'h0;
			spanw_q <= 12'h0;
		end else if (reg_wr) begin
			if (idx == REG_ROP) rop_q <= cq_out.word[3:0];
			if (idx == REG_MODE) mode_q <= cq_out.word[6:0];
			if (idx == REG_FG) fg_q <= cq_out.word;
			if (idx == REG_BG) bg_q <= cq_out.word;
			if (idx == REG_SCOPY) scopy_q <= cq_out.word;
			if (idx == REG_SPANW) spanw_q <= cq_out.word[11:0];
		end
	end

	// Line terms persist so continue and line-mode writes reuse them.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			lt_len_q   <= 6'h0;
			lt_err_q   <= 10'h0;
			lt_inc1_q  <= 10'h0;
			lt_inc2_q  <= 10'h0;
			lt_step1_q <= 12'h0;
			lt_step2_q <= 12'h0;
			lstart_q   <= 24'h0;
		end else begin
			if (terms_wr) begin
				lt_len_q   <= len_c;
				lt_err_q   <= err_c;
				lt_inc1_q  <= inc1_c;
				lt_inc2_q  <= inc2_c;
				lt_step1_q <= step1_c;
				lt_step2_q <= step2_c;
			end
			if (fb_wr & mode_q[2:0] == MODE_LINE) lstart_q <= cur_addr_q;
		end
	end

	// Parser sequencing: interlock drain, fill spans and copy phase.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q      <= ST_IDLE;
			fill_addr_q  <= 24'h0;
			fill_rem_q   <= 12'h0;
			fill_pat_q   <= 32'h0;
			copy_phase_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (reg_wr & (idx == REG_STATUS | idx == REG_ROP |
						idx == REG_MODE | idx == REG_SCOPY)) begin
						state_q <= ST_DRAIN;
					end else if (fb_wr & mode_q[2:0] == MODE_FILL & spanw_q != 12'h0) begin
						state_q     <= ST_SPAN;
						fill_addr_q <= cur_addr_q;
						fill_rem_q  <= spanw_q;
						fill_pat_q  <= cq_out.word;
					end
					if (fb_wr & mode_q[2:0] == MODE_COPY) copy_phase_q <= ~copy_phase_q;
					if (reg_wr & idx == REG_MODE) copy_phase_q <= 1'b0;
				end
				ST_DRAIN: if (drained) state_q <= ST_IDLE;
				ST_SPAN: if (pe_in_ready) begin
					fill_addr_q <= fill_addr_q + 24'(bpp_c << 5);
					if (fill_rem_q <= 12'(SPAN_MAX)) begin
						state_q    <= ST_IDLE;
						fill_rem_q <= 12'h0;
					end else begin
						fill_rem_q <= fill_rem_q - 12'(SPAN_MAX);
					end
				end
			endcase
		end
	end

	// small queue of predigested commands into the engine.
	stream_fifo #(.WIDTH($bits(pe_cmd_s)), .DEPTH(PEQ_DEPTH)) u_pe_queue (
		.clk       (core_clk),
		.rst_n     (rst_n),
		.in_valid  (pe_in_valid),
		.in_data   (pe_in),
		.in_ready  (pe_in_ready),
		.out_valid (pe_out_valid),
		.out_data  (pe_out),
		.out_ready (pe_pop)
	);

	pe_cmd_s     cmd_q;
	logic        busy_q, out_valid_q, m_take, adv, wen, bit_c, last_c;
	fb_wr_s      out_q;
	logic [5:0]  pix_q;
	logic [23:0] addr_q;
	logic [9:0]  err_q;
	logic [31:0] color_c, dcol_c;
	logic [1:0]  doff_c;
	logic [7:0]  r8_c, g8_c, b8_c;
	logic [11:0] lstep_c;
	logic [7:0]  be_c;
	logic [63:0] cbuf_q [CBUF_DEPTH];
	logic [2:0]  cb_wr_q, cb_rd_q;
	logic [3:0]  cb_cnt_q;
	logic        cb_pop;

	// Saturating ordered-dither add on one channel.
	function automatic logic [7:0] sat_add(input logic [7:0] c, input logic [7:0] o);
		logic [8:0] s;
		s = {1'b0, c} + {1'b0, o};
		sat_add = s[8] ? 8'hff : s[7:0];
	endfunction

	// stipple bit selects colour or no write
	// dither 24-bit colour to 8 or 16 bpp; 32 bpp passes undithered
	always_comb begin
		bit_c   = cmd_q.pattern[pix_q[4:0]];
		color_c = (cmd_q.kind == PE_PIXEL) ? cmd_q.pattern : (bit_c ? cmd_q.fg : cmd_q.bg);
		wen     = (cmd_q.kind != PE_SPAN & cmd_q.kind != PE_LINE) | bit_c | cmd_q.opaque;
		doff_c  = {addr_q[0] ^ addr_q[9], addr_q[9]};
		dcol_c  = color_c;
		// Channels are saturated first, then truncated, so bright colours never wrap.
		r8_c    = sat_add(color_c[23:16], {3'h0, doff_c, 3'h0});
		g8_c    = sat_add(color_c[15:8], {3'h0, doff_c, 3'h0});
		b8_c    = sat_add(color_c[7:0], {2'h0, doff_c, 4'h0});
		if (cmd_q.dither & cmd_q.depth == 2'h1) begin
			r8_c   = sat_add(color_c[23:16], {5'h0, doff_c, 1'b0});
			g8_c   = sat_add(color_c[15:8], {6'h0, doff_c});
			b8_c   = sat_add(color_c[7:0], {5'h0, doff_c, 1'b0});
			dcol_c = {16'h0, r8_c[7:3], g8_c[7:2], b8_c[7:3]};
		end else if (cmd_q.dither & cmd_q.depth == 2'h0) begin
			dcol_c = {24'h0, r8_c[7:5], g8_c[7:5], b8_c[7:6]};
		end
		// byte enables from pixel depth and alignment
		be_c    = ((8'h1 << (4'h1 << cmd_q.depth)) - 8'h1) << addr_q[2:0];
		// The chosen step carries its own sign into the address add.
		lstep_c = err_q[9] ? cmd_q.step2 : cmd_q.step1;
		last_c = (cmd_q.kind != PE_SPAN & cmd_q.kind != PE_LINE) | (pix_q + 6'h1 >= cmd_q.len);
	end

	// engine stalls while its output waits on the merge stage.
	assign adv    = busy_q & (~out_valid_q | m_take) & ~(cmd_q.kind == PE_CP_WR & cb_cnt_q == 4'h0);
	assign pe_pop = ~busy_q & pe_out_valid;
	assign cb_pop = adv & cmd_q.kind == PE_CP_WR;

	// one address per step of the line
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			cmd_q  <= '0;
			pix_q  <= 6'h0;
			addr_q <= 24'h0;
			err_q  <= 10'h0;
		end else if (pe_pop) begin
			cmd_q  <= pe_out;
			busy_q <= (pe_out.kind != PE_SPAN & pe_out.kind != PE_LINE) | (pe_out.len != 6'h0);
			pix_q  <= 6'h0;
			addr_q <= pe_out.addr;
			err_q  <= pe_out.err;
		end else if (adv) begin
			busy_q <= ~last_c;
			pix_q  <= pix_q + 6'h1;
			if (cmd_q.kind == PE_LINE) begin
				addr_q <= addr_q + {{12{lstep_c[11]}}, lstep_c};
				err_q  <= err_q + (err_q[9] ? cmd_q.inc1 : cmd_q.inc2);
			end else begin
				addr_q <= addr_q + 24'(12'h1 << cmd_q.depth);
			end
		end
	end

	// Engine output register toward the merge stage.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_q <= 1'b0;
			out_q       <= '0;
		end else if (adv) begin
			out_valid_q   <= wen;
			out_q.is_read <= (cmd_q.kind == PE_CP_RD);
			out_q.rmw     <= 1'b0;
			out_q.qaddr   <= addr_q[23:3];
			out_q.rop     <= cmd_q.rop;
			out_q.be      <= be_c;
			out_q.data    <= (cmd_q.depth == 2'h0) ? {8{dcol_c[7:0]}} :
				(cmd_q.depth == 2'h1) ? {4{dcol_c[15:0]}} : {2{dcol_c}};
			if (cmd_q.kind == PE_CP_WR) begin
				out_q.data <= cbuf_q[cb_rd_q];
				out_q.be   <= cmd_q.pattern[7:0];
			end
		end else if (m_take) begin
			out_valid_q <= 1'b0;
		end
	end

	// Copy buffer catches returned source quadwords in order.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cb_wr_q  <= 3'h0;
			cb_rd_q  <= 3'h0;
			cb_cnt_q <= 4'h0;
		end else begin
			if (copy_rd_valid) cb_wr_q <= cb_wr_q + 3'h1;
			if (cb_pop) cb_rd_q <= cb_rd_q + 3'h1;
			cb_cnt_q <= cb_cnt_q + 4'(copy_rd_valid) - 4'(cb_pop);
		end
	end
	always_ff @(posedge core_clk) begin
		if (copy_rd_valid) cbuf_q[cb_wr_q] <= copy_rd_data;
	end

	fb_wr_s held_q, wb_out;
	logic   held_valid_q, can_merge, push_held, wb_ready, wb_valid;
	logic [63:0] mdata_c;

	for (genvar b = 0; b < 8; b++) begin : g_merge
		assign mdata_c[b*8 +: 8] = out_q.be[b] ? out_q.data[b*8 +: 8] : held_q.data[b*8 +: 8];
	end

	// no merge on rop change or overlap
	assign can_merge = held_valid_q & ~held_q.is_read & ~out_q.is_read &
		held_q.qaddr == out_q.qaddr & held_q.rop == out_q.rop & (held_q.be & out_q.be) == 8'h0;
	assign push_held = held_valid_q & wb_ready & ((out_valid_q & ~can_merge) | ~wb_valid);
	assign m_take    = out_valid_q & (~held_valid_q | push_held | can_merge);

	// Merge holding register.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			held_valid_q <= 1'b0;
			held_q       <= '0;
		end else if (m_take & can_merge & ~push_held) begin
			held_q.data <= mdata_c;
			held_q.be   <= held_q.be | out_q.be;
		end else if (m_take) begin
			held_valid_q <= 1'b1;
			held_q       <= out_q;
			// flag writes whose rop reads destination
			// rop truth table indexed by source and destination
			held_q.rmw   <= ~out_q.is_read & (out_q.rop[0] != out_q.rop[1] | out_q.rop[2] != out_q.rop[3]);
		end else if (push_held) begin
			held_valid_q <= 1'b0;
		end
	end

	// 16-entry write buffer drained by memory
	stream_fifo #(.WIDTH($bits(fb_wr_s)), .DEPTH(WB_DEPTH)) u_write_buffer (
		.clk       (core_clk),
		.rst_n     (rst_n),
		.in_valid  (push_held),
		.in_data   (held_q),
		.in_ready  (wb_ready),
		.out_valid (wb_valid),
		.out_data  (wb_out),
		.out_ready (mem_wr_ready)
	);
	assign mem_wr_valid = wb_valid;
	assign mem_wr       = wb_out;

	// Pipeline is empty only when every stage holds nothing.
	assign drained = ~pe_out_valid & ~busy_q & ~out_valid_q & ~held_valid_q & ~wb_valid;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pipe_idle <= 1'b1;
		end else begin
			pipe_idle <= drained & (state_q == ST_IDLE) & ~cq_valid;
		end
	end
endmodule

// *** verification/gfx_pipe_checker.sv ***
// Port-level assertions of the drawing pipeline, bound to its top module.
`timescale 1ns/100ps
module gfx_pipe_checker (
	input wire logic               core_clk,
	input wire logic               reset_n,
	input wire logic               cq_wr_valid,
	input wire logic               cq_wr_is_read,
	input wire gfx_pkg::cq_entry_s cq_wr_entry,
	input wire logic               cq_wr_ready,
	input wire logic               copy_rd_valid,
	input wire logic [63:0]        copy_rd_data,
	input wire logic               mem_wr_valid,
	input wire gfx_pkg::fb_wr_s    mem_wr,
	input wire logic               mem_wr_ready,
	input wire logic               pipe_idle
);
	import gfx_pkg::*;
	logic       take;
	logic [7:0] taken_q;
	logic [1:0] age_q;

	// A word is taken only when it is a write and the queue has room.
	assign take = cq_wr_valid && cq_wr_ready && !cq_wr_is_read;

	// Pops are unseen here, so takes since idle only bound the fill level from above.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) taken_q <= 8'h00;
		else if (pipe_idle && !take) taken_q <= 8'h00;
		else if (take && taken_q != 8'hff) taken_q <= taken_q + 8'h01;
	end

	// Ages the release of reset so the synchroniser window is skipped.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) age_q <= 2'h0;
		else if (age_q != 2'h3) age_q <= age_q + 2'h1;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_take;
		cq_wr_valid && cq_wr_ready && !cq_wr_is_read;
	endsequence
	sequence s_stall;
		mem_wr_valid && !mem_wr_ready;
	endsequence

	a_held_write_stable: assert property (s_stall |=> mem_wr_valid && $stable(mem_wr))
		else $error("held write changed or vanished while stalled");
	a_rmw_flag_match: assert property (mem_wr_valid && !mem_wr.is_read |->
		mem_wr.rmw == ((mem_wr.rop[0] != mem_wr.rop[1]) || (mem_wr.rop[2] != mem_wr.rop[3])))
		else $error("rmw flag does not follow rop");
	a_write_lanes_set: assert property (mem_wr_valid && !mem_wr.is_read |-> mem_wr.be != 8'h00)
		else $error("write without byte lanes");
	a_take_wakes_pipe: assert property (s_take |-> ##[1:3] !pipe_idle)
		else $error("taken word left the pipe idle");
	a_read_stays_idle: assert property (pipe_idle && !take && !$past(take)
		&& !copy_rd_valid |=> pipe_idle)
		else $error("pipe woke without a taken write");
	a_idle_buffer_empty: assert property (pipe_idle |-> !mem_wr_valid)
		else $error("idle while the write buffer holds entries");
	a_full_after_depth: assert property (!cq_wr_ready && age_q == 2'h3 |-> taken_q >= 8'h3e)
		else $error("queue full before its depth was taken");
	a_ready_after_reset: assert property ($rose(reset_n) |-> ##3 cq_wr_ready && pipe_idle)
		else $error("queue not ready after reset");
endmodule

bind graphics_command_pipeline gfx_pipe_checker chk_i (
	.core_clk      (core_clk),
	.reset_n       (reset_n),
	.cq_wr_valid   (cq_wr_valid),
	.cq_wr_is_read (cq_wr_is_read),
	.cq_wr_entry   (cq_wr_entry),
	.cq_wr_ready   (cq_wr_ready),
	.copy_rd_valid (copy_rd_valid),
	.copy_rd_data  (copy_rd_data),
	.mem_wr_valid  (mem_wr_valid),
	.mem_wr        (mem_wr),
	.mem_wr_ready  (mem_wr_ready),
	.pipe_idle     (pipe_idle)
);

// *** verification/cmd_loader_model.sv ***
// Host-side loader model that feeds the command queue.
`timescale 1ns/100ps
module cmd_loader_model (
	input  wire logic          core_clk,
	input  wire logic          cq_wr_ready,
	output logic               cq_wr_valid,
	output logic               cq_wr_is_read,
	output gfx_pkg::cq_entry_s cq_wr_entry
);
	import gfx_pkg::*;
	logic [33:0] pend[$];

	// Nothing is offered at time zero.
	initial begin
		cq_wr_valid = 1'b0;
		cq_wr_is_read = 1'b0;
		cq_wr_entry = '0;
	end

	// caller orders deep
	// Deep register writes are queued as given; ordering them against drawing is the caller's job.
	task automatic put(input logic rd, input logic is_addr, input logic [31:0] word);
		pend.push_back({rd, is_addr, word});
	endtask

	function automatic int pending();
		return pend.size();
	endfunction

	// hold until taken
	// An offer stands until ready is seen at an edge; idle data toggles so stale words never pass.
	always @(posedge core_clk) begin
		if (cq_wr_valid && cq_wr_ready) void'(pend.pop_front());
		#1;
		cq_wr_valid = (pend.size() != 0);
		if (cq_wr_valid) {cq_wr_is_read, cq_wr_entry} = pend[0];
		else cq_wr_entry.word = ~cq_wr_entry.word;
	end
endmodule

// *** verification/graphics_command_pipeline_bench.sv ***
// Self-checking bench of the drawing pipeline.
`timescale 1ns/100ps
module graphics_command_pipeline_bench;
	import gfx_pkg::*;
	logic      core_clk;
	logic      reset_n;
	logic      cq_wr_valid;
	logic      cq_wr_is_read;
	logic      cq_wr_ready;
	cq_entry_s cq_wr_entry;
	logic      mem_wr_valid;
	logic      mem_wr_ready;
	logic      pipe_idle;
	fb_wr_s    mem_wr;
	int        num_errors;
	int        total_checks;
	int        n;

	graphics_command_pipeline dut (
		.core_clk      (core_clk),
		.reset_n       (reset_n),
		.cq_wr_valid   (cq_wr_valid),
		.cq_wr_is_read (cq_wr_is_read),
		.cq_wr_entry   (cq_wr_entry),
		.cq_wr_ready   (cq_wr_ready),
		.copy_rd_valid (1'b0),
		.copy_rd_data  (64'h0),
		.mem_wr_valid  (mem_wr_valid),
		.mem_wr        (mem_wr),
		.mem_wr_ready  (mem_wr_ready),
		.pipe_idle     (pipe_idle)
	);

	cmd_loader_model ld (
		.core_clk      (core_clk),
		.cq_wr_ready   (cq_wr_ready),
		.cq_wr_valid   (cq_wr_valid),
		.cq_wr_is_read (cq_wr_is_read),
		.cq_wr_entry   (cq_wr_entry)
	);

	// A 40 ns clock.
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr_fb(input logic [31:0] addr, input logic [31:0] data);
		ld.put(1'b0, 1'b1, addr);
		ld.put(1'b0, 1'b0, data);
	endtask

	task automatic wr_reg(input logic [5:0] idx, input logic [31:0] data);
		wr_fb({24'h800000, idx, 2'b00}, data);
	endtask

	// Waits, bounded, until the loader is empty and the pipe reports idle.
	task automatic wait_idle();
		int k;
		k = 0;
		repeat (4) @(negedge core_clk);
		while ((ld.pending() != 0 || pipe_idle !== 1'b1) && k < 3000) begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 3000) begin
			num_errors++;
			complete_run();
		end
	endtask

	// Takes the head write while ready is held high and checks every field.
	task automatic exp_wr(input logic [20:0] q, input logic [63:0] d, input logic [7:0] be,
		input logic [3:0] r);
		fb_wr_s      w;
		logic [63:0] m;
		int          k;
		k = 0;
		@(negedge core_clk);
		while (mem_wr_valid !== 1'b1 && k < 300) begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 300) begin
			num_errors++;
			complete_run();
		end
		w = mem_wr;
		@(posedge core_clk);
		for (k = 0; k < 8; k++) m[k*8 +: 8] = {8{be[k]}};
		chk("qaddr", {43'h0, q}, {43'h0, w.qaddr});
		chk("be", {56'h0, be}, {56'h0, w.be});
		chk("data", d & m, w.data & m);
		chk("rop", {60'h0, r}, {60'h0, w.rop});
		chk("rmw", {63'h0, (r[0] != r[1]) || (r[2] != r[3])}, {63'h0, w.rmw});
		chk("is_read", 64'h0, {63'h0, w.is_read});
	endtask

	// Main sequence: reset, merging burst, rop table, stipple, read drop, queue full.
	initial begin
		num_errors = 0;
		total_checks = 0;
		reset_n = 1'b0;
		mem_wr_ready = 1'b0;
		repeat (12) @(posedge core_clk);
		#1 reset_n = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk("ready", 64'h1, {63'h0, cq_wr_ready});
		chk("wr valid", 64'h0, {63'h0, mem_wr_valid});
		chk("idle", 64'h1, {63'h0, pipe_idle});
		$display("test reset done");

		// Burst into a stalled buffer: first word flushes alone, the next two merge.
		wr_reg(REG_MODE, 32'h20); // Simple mode at 32 bits per pixel.
		ld.put(1'b0, 1'b1, 32'h24);
		ld.put(1'b0, 1'b0, 32'h11111111);
		ld.put(1'b0, 1'b0, 32'h22222222);
		ld.put(1'b0, 1'b0, 32'h33333333);
		wr_fb(32'h2c, 32'h44444444);
		repeat (60) @(posedge core_clk);
		#1 mem_wr_ready = 1'b1;
		exp_wr(21'h4, 64'h11111111_00000000, 8'hf0, ROP_RESET);
		exp_wr(21'h5, 64'h33333333_22222222, 8'hff, ROP_RESET);
		exp_wr(21'h5, 64'h44444444_00000000, 8'hf0, ROP_RESET);
		$display("test burst merge done");

		// Every one of the sixteen raster operations reaches the write.
		for (int r = 0; r < 16; r++) begin
			wr_reg(REG_ROP, r);
			wr_fb(32'h40, 32'h11223344);
			exp_wr(21'h8, 64'h11223344, 8'h0f, r[3:0]);
		end
		wr_reg(REG_ROP, {28'h0, ROP_RESET});
		wait_idle();
		$display("test rop table done");

		// Transparent stipple: only set pattern bits write the foreground colour.
		wr_reg(REG_FG, 32'h5a5a00ff);
		wr_reg(REG_MODE, {26'h0, 2'h2, 1'b0, MODE_STIPPLE});
		wr_fb(32'h80, 32'h00000005);
		exp_wr(21'h10, 64'h5a5a00ff, 8'h0f, ROP_RESET);
		exp_wr(21'h11, 64'h5a5a00ff, 8'h0f, ROP_RESET);
		#1 mem_wr_ready = 1'b0;
		repeat (60) @(posedge core_clk);
		#1;
		chk("stipple extra", 64'h0, {63'h0, mem_wr_valid});
		mem_wr_ready = 1'b1;
		wr_reg(REG_MODE, 32'h20);
		wait_idle();
		$display("test stipple done");

		// Read-tagged words are dropped and leave the pipe idle.
		ld.put(1'b1, 1'b1, 32'h80);
		ld.put(1'b1, 1'b0, 32'h1);
		repeat (20) @(posedge core_clk);
		#1;
		chk("idle", 64'h1, {63'h0, pipe_idle});
		chk("wr valid", 64'h0, {63'h0, mem_wr_valid});
		$display("test read drop done");

		// Stall the buffer until the queue refuses, then drain everything in order.
		mem_wr_ready = 1'b0;
		for (int i = 0; i < 64; i++) wr_fb(32'h1000 + i * 8, i);
		n = 0;
		while (cq_wr_ready !== 1'b0 && n < 2000) begin
			@(negedge core_clk);
			n++;
		end
		chk("queue full", 64'h0, {63'h0, cq_wr_ready});
		if (n >= 2000) complete_run();
		@(posedge core_clk);
		#1 mem_wr_ready = 1'b1;
		for (int i = 0; i < 64; i++) exp_wr(21'h200 + i, i, 8'h0f, ROP_RESET);
		wait_idle();
		$display("test queue full done");
		complete_run();
	end
endmodule
